// file: verilog/opmode_pkg.sv
package opmode_pkg;
    typedef enum logic [2:0] {
        ST_INIT = 3'h0,
        ST_NORMAL = 3'h1,
        ST_STOP = 3'h2,
        ST_SLEEP = 3'h3,
        ST_RESTART = 3'h4,
        ST_FAILSAFE = 3'h5
    } op_state_t;
    // Mode field codes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_STOP = 2'h2;
    localparam logic [1:0] MODE_SOFT_RESET = 2'h3;
    // Timing, times in microseconds
    localparam int CLK_MHZ = 200;
    localparam int LONG_OPEN_WINDOW_TIME_US = 200;
    localparam int RESET_DELAY_TIME_ONE_US = 10;
    localparam int RESET_DELAY_TIME_TWO_US = 2;
    localparam int LONG_WINDOW_CYC = LONG_OPEN_WINDOW_TIME_US * CLK_MHZ;
    localparam int RD1_CYC = RESET_DELAY_TIME_ONE_US * CLK_MHZ;
    localparam int RD2_CYC = RESET_DELAY_TIME_TWO_US * CLK_MHZ;
    localparam int CNT_W = 17;
    // Serial frame layout, first bit shifted lands in bit 15
    localparam int FRAME_BITS = 16;
    localparam int BITCNT_W = 5;
    localparam int FR_WR = 15;
    localparam int FR_ADDR_MSB = 14;
    localparam int FR_ADDR_LSB = 8;
    localparam int FR_MODE_MSB = 7;
    localparam int FR_MODE_LSB = 6;
    localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
    localparam logic [6:0] ADDR_WD_CTRL = 7'h03;
    // Pin indices into the synchroniser vector
    localparam int PIN_TEST = 0;
    localparam int PIN_IRQ = 1;
    localparam int PIN_WK_CAN = 2;
    localparam int PIN_WK_PIN = 3;
    localparam int PIN_WK_GPIO = 4;
    localparam int PIN_OT = 5;
    localparam int PIN_UV = 6;
    localparam int PIN_CRIT = 7;
    localparam int PIN_SCLK = 8;
    localparam int PIN_CSN = 9;
    localparam int PIN_SDI = 10;
    localparam int NUM_PINS = 11;
    localparam logic [NUM_PINS-1:0] SYNC_RST = 11'h200;
endpackage

// file: verilog/operating_mode_controller.sv
`timescale 1ns/1ps
module operating_mode_controller
    import opmode_pkg::*;
#(
    parameter int LW_CYC = LONG_WINDOW_CYC,
    parameter int RD1_CYC_P = RD1_CYC,
    parameter int RD2_CYC_P = RD2_CYC
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic test_pin,
    input wire logic irq_output_low_in,
    input wire logic can_wake,
    input wire logic wake_input_pin,
    input wire logic gpio_wake,
    input wire logic overtemp,
    input wire logic main_uv,
    input wire logic critical_fail,
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic spi_sdi,
    input wire logic aux_supply_req,
    output logic reset_output_low,
    output logic irq_output_low_out,
    output logic irq_output_low_oe,
    output logic main_supply_rail_en,
    output logic aux_supply_rail_en,
    output logic can_force_normal,
    output logic dev_mode,
    output logic cfg0_state,
    output logic watchdog_fail,
    output logic [1:0] mode_field,
    output logic [2:0] op_state
);
    localparam logic [CNT_W-1:0] LW_LOAD = CNT_W'(LW_CYC - 1);
    localparam logic [CNT_W-1:0] RD1_LOAD = CNT_W'(RD1_CYC_P - 1);
    localparam logic [CNT_W-1:0] RD2_LOAD = CNT_W'(RD2_CYC_P - 1);
    localparam logic [BITCNT_W-1:0] FRAME_LEN = BITCNT_W'(FRAME_BITS);

    logic [NUM_PINS-1:0] pins;
    logic [NUM_PINS-1:0] sync1_reg;
    logic [NUM_PINS-1:0] sync2_reg;
    op_state_t state_reg;
    op_state_t state_next;
    logic rst_n_reg;
    logic rst_n_next;
    logic [CNT_W-1:0] dly_cnt_reg;
    logic [CNT_W-1:0] wd_cnt_reg;
    logic dev_reg;
    logic cfg0_reg;
    logic ot_cause_reg;
    logic wd_fail_reg;
    logic main_en_reg;
    logic aux_en_reg;
    logic [1:0] mode_reg;
    logic sclk_d_reg;
    logic csn_d_reg;
    logic [FRAME_BITS-1:0] shift_reg;
    logic [BITCNT_W-1:0] bitcnt_reg;
    logic sclk_rise;
    logic frame_end;
    logic frame_ok;
    logic is_write;
    logic mode_wr;
    logic wd_trig;
    logic [1:0] mode_code;
    op_state_t mode_target;
    logic wake_any;
    logic fs_req;
    logic wd_run;
    logic wd_expire;
    logic rel_pulse;
    op_state_t wd_target;

    assign pins = {spi_sdi, spi_csn, spi_sclk, critical_fail, main_uv, overtemp,
                   gpio_wake, wake_input_pin, can_wake, irq_output_low_in, test_pin};

    // Two-stage synchronisers for every pin input
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (srst) begin
                    sync1_reg[gi] <= SYNC_RST[gi];
                    sync2_reg[gi] <= SYNC_RST[gi];
                end else begin
                    sync1_reg[gi] <= pins[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    // Edge history of serial clock and select
    always_ff @(posedge mclk) begin
        if (srst) begin
            sclk_d_reg <= 1'b0;
            csn_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sync2_reg[PIN_SCLK];
            csn_d_reg <= sync2_reg[PIN_CSN];
        end
    end

    assign sclk_rise = sync2_reg[PIN_SCLK] && !sclk_d_reg && !sync2_reg[PIN_CSN];
    assign frame_end = sync2_reg[PIN_CSN] && !csn_d_reg;

    // Frame shifter, bit count saturates on long frames
    always_ff @(posedge mclk) begin
        if (srst) begin
            shift_reg <= '0;
            bitcnt_reg <= '0;
        end else if (sync2_reg[PIN_CSN]) begin
            bitcnt_reg <= '0;
        end else if (sclk_rise) begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], sync2_reg[PIN_SDI]};
            if (bitcnt_reg != '1) begin
                bitcnt_reg <= bitcnt_reg + 1'b1;
            end
        end
    end

    // Frame decode, only whole 16-bit frames count
    assign frame_ok = frame_end && (bitcnt_reg == FRAME_LEN);
    assign is_write = frame_ok && shift_reg[FR_WR];
    assign mode_wr = is_write && (shift_reg[FR_ADDR_MSB:FR_ADDR_LSB] == ADDR_MODE_CTRL);
    assign wd_trig = is_write && (shift_reg[FR_ADDR_MSB:FR_ADDR_LSB] == ADDR_WD_CTRL);
    assign mode_code = shift_reg[FR_MODE_MSB:FR_MODE_LSB];

    // Target state of a mode write
    always_comb begin
        case (mode_code)
            MODE_SLEEP: mode_target = ST_SLEEP;
            MODE_STOP: mode_target = ST_STOP;
            MODE_SOFT_RESET: mode_target = ST_INIT;
            default: mode_target = ST_NORMAL;
        endcase
    end

    // Event sources
    assign wake_any = sync2_reg[PIN_WK_CAN] || sync2_reg[PIN_WK_PIN] || sync2_reg[PIN_WK_GPIO];
    assign fs_req = sync2_reg[PIN_CRIT] || sync2_reg[PIN_OT];
    assign wd_target = cfg0_reg ? ST_RESTART : ST_FAILSAFE;

    // Watchdog only runs in init and normal, never in development
    assign wd_run = rst_n_reg && !dev_reg && (state_reg == ST_INIT || state_reg == ST_NORMAL);
    assign wd_expire = wd_run && (wd_cnt_reg == '0) && !wd_trig;

    // Mode transitions
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_INIT: begin
                // Wake inputs are not looked at here
                if (wd_expire) begin
                    state_next = wd_target;
                end else if (frame_ok) begin
                    state_next = mode_wr ? mode_target : ST_NORMAL;
                end
            end
            ST_NORMAL, ST_STOP: begin
                if (fs_req) begin
                    state_next = ST_FAILSAFE;
                end else if (sync2_reg[PIN_UV]) begin
                    state_next = ST_RESTART;
                end else if (wd_expire) begin
                    state_next = wd_target;
                end else if (mode_wr) begin
                    state_next = mode_target;
                end
            end
            ST_SLEEP: begin
                if (wake_any) begin
                    state_next = ST_RESTART;
                end
            end
            ST_RESTART: begin
                if (fs_req) begin
                    state_next = ST_FAILSAFE;
                end else if (!sync2_reg[PIN_UV] && dly_cnt_reg == '0) begin
                    state_next = ST_NORMAL;
                end
            end
            ST_FAILSAFE: begin
                if (wake_any || (ot_cause_reg && !sync2_reg[PIN_OT])) begin
                    state_next = ST_RESTART;
                end
            end
            default: state_next = ST_INIT;
        endcase
    end

    // State register, power-on starts in init
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= ST_INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // Reset output: low in restart and before the first release
    always_comb begin
        case (state_next)
            ST_RESTART: rst_n_next = 1'b0;
            ST_INIT: rst_n_next = rst_n_reg || (state_reg == ST_INIT && dly_cnt_reg == '0);
            default: rst_n_next = 1'b1;
        endcase
    end
    assign rel_pulse = !rst_n_reg && rst_n_next;

    always_ff @(posedge mclk) begin
        if (srst) begin
            rst_n_reg <= 1'b0;
        end else begin
            rst_n_reg <= rst_n_next;
        end
    end

    // Reset delay counter, reloaded in restart while undervoltage persists
    always_ff @(posedge mclk) begin
        if (srst) begin
            dly_cnt_reg <= RD1_LOAD;
        end else if (state_next == ST_RESTART && state_reg != ST_RESTART) begin
            dly_cnt_reg <= sync2_reg[PIN_UV] ? RD1_LOAD : RD2_LOAD;
        end else if (state_reg == ST_RESTART && sync2_reg[PIN_UV]) begin
            dly_cnt_reg <= RD1_LOAD;
        end else if (!rst_n_reg && dly_cnt_reg != '0) begin
            dly_cnt_reg <= dly_cnt_reg - 1'b1;
        end
    end

    // Watchdog counter, long window reloaded until running
    always_ff @(posedge mclk) begin
        if (srst) begin
            wd_cnt_reg <= LW_LOAD;
        end else if (!wd_run || wd_trig) begin
            wd_cnt_reg <= LW_LOAD;
        end else if (wd_cnt_reg != '0) begin
            wd_cnt_reg <= wd_cnt_reg - 1'b1;
        end
    end

    // Failure pulse
    always_ff @(posedge mclk) begin
        if (srst) begin
            wd_fail_reg <= 1'b0;
        end else begin
            wd_fail_reg <= wd_expire;
        end
    end

    // Straps caught at the release of the reset output, the test pin only at release from init
    always_ff @(posedge mclk) begin
        if (srst) begin
            dev_reg <= 1'b0;
            cfg0_reg <= 1'b0;
        end else if (rel_pulse) begin
            cfg0_reg <= sync2_reg[PIN_IRQ];
            if (state_reg == ST_INIT) begin
                dev_reg <= sync2_reg[PIN_TEST];
            end
        end
    end

    // Remembers that overtemperature caused fail-safe
    always_ff @(posedge mclk) begin
        if (srst) begin
            ot_cause_reg <= 1'b0;
        end else if (state_next == ST_FAILSAFE && state_reg != ST_FAILSAFE) begin
            ot_cause_reg <= sync2_reg[PIN_OT] && !sync2_reg[PIN_CRIT];
        end
    end

    // Mode field follows mode writes, back to normal in restart and init, kept on entering fail-safe
    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_reg <= MODE_NORMAL;
        end else if (state_next == ST_RESTART || state_next == ST_INIT) begin
            mode_reg <= MODE_NORMAL;
        end else if (mode_wr && state_next == mode_target) begin
            mode_reg <= mode_code;
        end
    end

    // Supply and transceiver controls
    always_ff @(posedge mclk) begin
        if (srst) begin
            main_en_reg <= 1'b1;
            aux_en_reg <= 1'b0;
        end else begin
            main_en_reg <= !(state_next == ST_SLEEP || state_next == ST_FAILSAFE);
            aux_en_reg <= dev_reg || aux_supply_req;
        end
    end

    assign reset_output_low = rst_n_reg;
    assign irq_output_low_out = 1'b0;
    assign irq_output_low_oe = !rst_n_reg;
    assign main_supply_rail_en = main_en_reg;
    assign aux_supply_rail_en = aux_en_reg;
    assign can_force_normal = dev_reg;
    assign dev_mode = dev_reg;
    assign cfg0_state = cfg0_reg;
    assign watchdog_fail = wd_fail_reg;
    assign mode_field = mode_reg;
    assign op_state = state_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_por_init;
        $past(srst) |-> state_reg == ST_INIT;
    endproperty
    a_por_init: assert property (p_por_init)
        else $error("not in init after reset");

    property p_restart_rst;
        state_reg == ST_RESTART |-> !reset_output_low && irq_output_low_oe;
    endproperty
    a_restart_rst: assert property (p_restart_rst)
        else $error("reset released in restart");

    property p_restart_exit;
        state_reg == ST_RESTART && !fs_req && !sync2_reg[PIN_UV] && dly_cnt_reg == '0
            |=> state_reg == ST_NORMAL && reset_output_low;
    endproperty
    a_restart_exit: assert property (p_restart_exit)
        else $error("restart did not end in normal");

    property p_failsafe_hold;
        state_reg == ST_FAILSAFE && !wake_any && !(ot_cause_reg && !sync2_reg[PIN_OT])
            |=> state_reg == ST_FAILSAFE && !main_supply_rail_en;
    endproperty
    a_failsafe_hold: assert property (p_failsafe_hold)
        else $error("fail-safe left without cause");

    property p_stop_sleep;
        (state_reg == ST_STOP |-> main_supply_rail_en) and
        (state_reg == ST_SLEEP |-> !main_supply_rail_en);
    endproperty
    a_stop_sleep: assert property (p_stop_sleep)
        else $error("main supply wrong in stop or sleep");

    property p_dev;
        dev_mode |=> !watchdog_fail && can_force_normal && aux_supply_rail_en;
    endproperty
    a_dev: assert property (p_dev)
        else $error("development mode controls wrong");

    property p_strap;
        rel_pulse && state_reg == ST_INIT
            |=> dev_mode == $past(sync2_reg[PIN_TEST]) && cfg0_state == $past(sync2_reg[PIN_IRQ]);
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap capture wrong");

    property p_init_frame;
        state_reg == ST_INIT && !wd_expire && frame_ok && !mode_wr |=> state_reg == ST_NORMAL;
    endproperty
    a_init_frame: assert property (p_init_frame)
        else $error("frame in init did not enter normal");

    property p_wd_fail;
        wd_expire |=> watchdog_fail && (state_reg == ST_RESTART || state_reg == ST_FAILSAFE);
    endproperty
    a_wd_fail: assert property (p_wd_fail)
        else $error("watchdog expiry not acted on");

    property p_mode_clear;
        state_reg == ST_RESTART |-> mode_field == MODE_NORMAL;
    endproperty
    a_mode_clear: assert property (p_mode_clear)
        else $error("mode field not cleared in restart");

    property p_init_wake;
        state_reg == ST_INIT && !frame_ok && !wd_expire |=> state_reg == ST_INIT;
    endproperty
    a_init_wake: assert property (p_init_wake)
        else $error("init left without frame or failure");
endmodule

// file: verification/spi_master_model.sv
`timescale 1ns/1ps
// Microcontroller side: SPI mode 0 master sending whole 16-bit words
module spi_master_model (
    input wire logic mclk,
    output logic spi_sclk,
    output logic spi_csn,
    output logic spi_sdi
);
    // Idle bus: clock low, select high, data line low
    initial begin
        spi_sclk = 1'b0;
        spi_csn = 1'b1;
        spi_sdi = 1'b0;
    end

    // One frame, MSB first, slow clock of 4 mclk high and 4 low
    task automatic send(input logic [15:0] word);
        int i;
        @(negedge mclk);
        spi_csn = 1'b0;
        for (i = 15; i >= 0; i--) begin
            spi_sdi = word[i];
            repeat (4) @(negedge mclk);
            spi_sclk = 1'b1;
            repeat (4) @(negedge mclk);
            spi_sclk = 1'b0;
        end
        repeat (2) @(negedge mclk);
        spi_csn = 1'b1;
        spi_sdi = ~spi_sdi; // Released line shows no stale value
        repeat (8) @(negedge mclk); // Gap lets the frame land
    endtask
endmodule

// file: verification/test_operating_mode_controller.sv
`timescale 1ns/1ps
module test_operating_mode_controller
    import opmode_pkg::*;
;
    localparam int LW = 40;
    localparam int RD1 = 8;
    localparam int RD2 = 4;
    localparam logic [15:0] TRIG = {1'b1, ADDR_WD_CTRL, 8'h00};
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic test_pin = 1'b0;
    logic irq_in = 1'b1;
    logic wake_pin = 1'b0;
    logic overtemp = 1'b0;
    logic can_wake = 1'b0;
    logic gpio_wake = 1'b0;
    logic main_uv = 1'b0;
    logic critical_fail = 1'b0;
    logic aux_supply_req = 1'b0;
    logic sclk, csn, sdi;
    logic reset_output_low, irq_out, irq_oe, main_en, aux_en, can_fn, dev_mode, cfg0;
    logic watchdog_fail;
    logic [1:0] mode_field;
    logic [2:0] op_state;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;

    // Clock at 200 MHz
    always #2.5 mclk = ~mclk;

    operating_mode_controller #(.LW_CYC(LW), .RD1_CYC_P(RD1), .RD2_CYC_P(RD2)) i_dut (
        .mclk(mclk), .srst(srst), .test_pin(test_pin), .irq_output_low_in(irq_in),
        .can_wake(can_wake), .wake_input_pin(wake_pin), .gpio_wake(gpio_wake),
        .overtemp(overtemp), .main_uv(main_uv), .critical_fail(critical_fail),
        .spi_sclk(sclk), .spi_csn(csn), .spi_sdi(sdi), .aux_supply_req(aux_supply_req),
        .reset_output_low(reset_output_low), .irq_output_low_out(irq_out),
        .irq_output_low_oe(irq_oe), .main_supply_rail_en(main_en),
        .aux_supply_rail_en(aux_en), .can_force_normal(can_fn), .dev_mode(dev_mode),
        .cfg0_state(cfg0), .watchdog_fail(watchdog_fail), .mode_field(mode_field),
        .op_state(op_state)
    );

    spi_master_model i_spi (.mclk(mclk), .spi_sclk(sclk), .spi_csn(csn), .spi_sdi(sdi));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Bounded wait for a state, then compare
    task automatic wait_st(input logic [2:0] s, input int n, input string what);
        int i;
        for (i = 0; i < n && op_state !== s; i++) @(negedge mclk);
        check(what, op_state, s);
    endtask

    // Stay in restart with reset held, then leave to normal after the delay dly
    task automatic restart_exit(input string what, input int dly);
        int n;
        n = 0;
        while (op_state === ST_RESTART && n < 100) begin
            check("reset held", reset_output_low, 1'b0);
            n++;
            @(negedge mclk);
        end
        check(what, (n >= dly - 1 && n <= dly + 2), 1'b1);
        wait_st(ST_NORMAL, 3, "normal after restart");
        check("mode cleared", mode_field, MODE_NORMAL);
    endtask

    task automatic do_reset();
        @(negedge mclk);
        srst = 1'b1;
        repeat (3) @(negedge mclk);
        check("init state", op_state, ST_INIT);
        check("reset low", reset_output_low, 1'b0);
        check("irq pulled low", irq_oe, 1'b1);
        check("irq drive level", irq_out, 1'b0);
        srst = 1'b0;
        for (int i = 0; i < RD1 + 10 && reset_output_low !== 1'b1; i++) @(negedge mclk);
        check("reset released", reset_output_low, 1'b1);
        check("irq released", irq_oe, 1'b0);
    endtask

    // Missed trigger, strap pull-up sends the failure to restart, then fail-safe
    task automatic test_watchdog();
        int n;
        do_reset();
        check("strap pull-up", cfg0, 1'b1);
        n = 0;
        while (watchdog_fail !== 1'b1 && n < LW + 10) begin
            n++;
            @(negedge mclk);
        end
        check("long window", (n >= LW - 2 && n <= LW + 3), 1'b1);
        wait_st(ST_RESTART, 4, "wd restart");
        irq_in = 1'b0;
        restart_exit("wd restart time", RD2);
        check("strap no pull-up", cfg0, 1'b0);
        wait_st(ST_FAILSAFE, LW + 10, "wd fail-safe");
        aux_supply_req = 1'b1;
        repeat (10) @(negedge mclk);
        check("aux on request", aux_en, 1'b1);
        aux_supply_req = 1'b0;
        repeat (10) @(negedge mclk);
        check("aux off", aux_en, 1'b0);
        check("fail-safe holds", op_state, ST_FAILSAFE);
        check("main off fail-safe", main_en, 1'b0);
        wake_pin = 1'b1;
        wait_st(ST_RESTART, 6, "wake from fail-safe");
        wake_pin = 1'b0;
        restart_exit("fail-safe restart time", RD2);
        $display("test watchdog done");
    endtask

    // Strap test pin high during init: watchdog halted, wakes ignored
    task automatic test_dev_init();
        test_pin = 1'b1;
        do_reset();
        repeat (2) @(negedge mclk);
        check("dev mode", dev_mode, 1'b1);
        check("can normal", can_fn, 1'b1);
        check("aux on", aux_en, 1'b1);
        wake_pin = 1'b1;
        for (int i = 0; i < 3 * LW; i++) begin
            @(negedge mclk);
            check("no wd fail", watchdog_fail, 1'b0);
        end
        wake_pin = 1'b0;
        check("wake ignored", op_state, ST_INIT);
        i_spi.send(TRIG);
        wait_st(ST_NORMAL, 4, "frame leaves init");
        $display("test dev init done");
    endtask

    // Mode writes in development mode
    task automatic test_modes();
        i_spi.send({1'b1, ADDR_MODE_CTRL, MODE_STOP, 6'h00});
        wait_st(ST_STOP, 4, "stop entered");
        check("stop field", mode_field, MODE_STOP);
        check("main on stop", main_en, 1'b1);
        i_spi.send({1'b1, ADDR_MODE_CTRL, MODE_NORMAL, 6'h00});
        wait_st(ST_NORMAL, 4, "normal again");
        i_spi.send({1'b1, ADDR_MODE_CTRL, MODE_SLEEP, 6'h00});
        wait_st(ST_SLEEP, 4, "sleep entered");
        check("main off sleep", main_en, 1'b0);
        @(negedge mclk);
        wake_pin = 1'b1;
        wait_st(ST_RESTART, 6, "wake from sleep");
        wake_pin = 1'b0;
        restart_exit("sleep restart time", RD2);
        overtemp = 1'b1;
        wait_st(ST_FAILSAFE, 6, "overtemp fail-safe");
        check("main off ot", main_en, 1'b0);
        overtemp = 1'b0;
        wait_st(ST_RESTART, 6, "cooldown restart");
        restart_exit("cooldown restart time", RD2);
        i_spi.send({1'b1, ADDR_MODE_CTRL, MODE_SOFT_RESET, 6'h00});
        wait_st(ST_INIT, 4, "soft reset");
        $display("test modes done");
    endtask

    // Undervoltage stretches restart, critical failure waits for a wake
    task automatic test_faults();
        i_spi.send(TRIG);
        wait_st(ST_NORMAL, 4, "frame leaves init again");
        main_uv = 1'b1;
        wait_st(ST_RESTART, 6, "uv restart");
        repeat (RD1 + 4) @(negedge mclk);
        check("uv holds restart", op_state, ST_RESTART);
        main_uv = 1'b0;
        restart_exit("uv restart time", RD1 + 2);
        critical_fail = 1'b1;
        wait_st(ST_FAILSAFE, 6, "critical fail-safe");
        critical_fail = 1'b0;
        repeat (10) @(negedge mclk);
        check("crit fail-safe holds", op_state, ST_FAILSAFE);
        check("main off crit", main_en, 1'b0);
        can_wake = 1'b1;
        wait_st(ST_RESTART, 6, "can wake");
        can_wake = 1'b0;
        restart_exit("can wake restart time", RD2);
        i_spi.send({1'b1, ADDR_MODE_CTRL, MODE_SLEEP, 6'h00});
        wait_st(ST_SLEEP, 4, "sleep again");
        gpio_wake = 1'b1;
        wait_st(ST_RESTART, 6, "gpio wake");
        gpio_wake = 1'b0;
        restart_exit("gpio restart time", RD2);
        $display("test faults done");
    endtask

    // Cycle ceiling against a hang
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        test_watchdog();
        test_dev_init();
        test_modes();
        test_faults();
        conclude();
    end
endmodule
